// ==== pkg/spi_pkg.sv ====
package spi_pkg;

  localparam int SFR_W = 8;

  // Register addresses on the special function register port
  localparam logic [7:0] ADDR_DATA = 8'h43;
  localparam logic [7:0] ADDR_CFG  = 8'ha1;
  localparam logic [7:0] ADDR_DIV  = 8'ha2;
  localparam logic [7:0] ADDR_CTL  = 8'hf8;

  // Values after reset
  localparam logic [7:0] CTL_RESET  = 8'h06;
  localparam logic [7:0] DIV_RESET  = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Control register fields
  localparam int CTL_DONE    = 7;
  localparam int CTL_WRITE_COLLISION_FLAG    = 6;
  localparam int CTL_MODE_FAULT_FLAG    = 5;
  localparam int CTL_OVR     = 4;
  localparam int CTL_MODE_HI = 3;
  localparam int CTL_MODE_LO = 2;
  localparam int CTL_TX_BUFFER_EMPTY   = 1;
  localparam int CTL_EN      = 0;

  // Configuration register fields
  localparam int CFG_BUSY   = 7;
  localparam int CFG_MASTER = 6;
  localparam int CFG_CPHA   = 5;
  localparam int CFG_CPOL   = 4;
  localparam int CFG_SLVSEL = 3;
  localparam int CFG_NSSIN  = 2;
  localparam int CFG_SRMT   = 1;
  localparam int CFG_RXBMT  = 0;

  // Positions of the pins in the synchroniser vector
  localparam int PIN_SCK  = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_NSS  = 3;

  typedef enum logic [1:0] {
    SEL_3WIRE     = 2'b00,
    SEL_4WIRE_IN  = 2'b01,
    SEL_DRIVE_LO  = 2'b10,
    SEL_DRIVE_HI  = 2'b11
  } select_mode_e;

  typedef enum logic [0:0] {
    M_IDLE = 1'b0,
    M_RUN  = 1'b1
  } master_state_e;

  // Timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int T_LAST_MIN_NS  = 600;
  localparam int T_LAST_MAX_NS  = 800;
  localparam int SYNC_LAT_CYC   = 3;
  localparam int LAST_MIN_CYC   = (T_LAST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] LAST_HOLD = 3'(LAST_MIN_CYC - SYNC_LAT_CYC);
  localparam logic [2:0] LAST_BIT  = 3'h7;
  localparam logic [4:0] LAST_HALF = 5'h0f;

endpackage

// ==== pkg/spi_rate_if.sv ====
interface spi_rate_if;
  logic       run;
  logic [7:0] divider;
  logic       tick;
  modport ctl (output run, output divider, input tick);
  modport gen (input run, input divider, output tick);
endinterface

// ==== core/spi_rate_gen.sv ====
module spi_rate_gen (
  // Clock and reset
  input  logic       clk_sys_i,
  input  logic       rst_n_i,
  input  logic       ce_i,
  // Rate request and tick
  spi_rate_if.gen    rate
);
  logic [7:0] cnt_reg;
  logic       tick_reg;

  assign rate.tick = tick_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg  <= 8'h00;
      tick_reg <= 1'b0;
    end else if (ce_i) begin
      if (!rate.run) begin
        cnt_reg  <= 8'h00;
        tick_reg <= 1'b0;
      end else if (cnt_reg == rate.divider) begin
        cnt_reg  <= 8'h00;
        tick_reg <= 1'b1;
      end else begin
        cnt_reg  <= cnt_reg + 8'h01;
        tick_reg <= 1'b0;
      end
    end
  end
endmodule // spi_rate_gen

// ==== core/spi_port.sv ====
module spi_port (
  // Clock, reset, enable
  input  logic                       clk_sys_i,
  input  logic                       rst_n_i,
  input  logic                       ce_i,
  // Special function register port
  input  logic [spi_pkg::SFR_W-1:0]  sfr_addr_i,
  input  logic                       sfr_wr_i,
  input  logic                       sfr_rd_i,
  input  logic [spi_pkg::SFR_W-1:0]  sfr_wdata_i,
  output logic [spi_pkg::SFR_W-1:0]  sfr_rdata_o,
  // Interrupt request
  output logic                       irq_o,
  // Serial clock pin
  input  logic                       sck_i,
  output logic                       sck_o,
  output logic                       sck_oe_o,
  // Master-out pin
  input  logic                       mosi_i,
  output logic                       mosi_o,
  output logic                       mosi_oe_o,
  // Master-in pin
  input  logic                       miso_i,
  output logic                       miso_o,
  output logic                       miso_oe_o,
  // Select pin, active low
  input  logic                       slave_select_n_i,
  output logic                       slave_select_n_o,
  output logic                       slave_select_n_oe_o
);
  import spi_pkg::*;

  function automatic logic [7:0] shl_in(input logic [7:0] v, input logic b);
    shl_in = {v[6:0], b};
  endfunction

  // Pin synchronisers: a change counts once stages two and three agree
  logic [3:0] s1_reg, s2_reg, s3_reg, filt_reg;
  wire  [3:0] pins_w  = {slave_select_n_i, miso_i, mosi_i, sck_i};
  wire  [3:0] agree_w = ~(s2_reg ^ s3_reg);
  wire  [3:0] pin_now = (agree_w & s3_reg) | (~agree_w & filt_reg);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg   <= 4'hf;
      s2_reg   <= 4'hf;
      s3_reg   <= 4'hf;
      filt_reg <= 4'hf;
    end else if (ce_i) begin
      s1_reg   <= pins_w;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= pin_now;
    end
  end

  // Software visible state
  logic          done_reg, write_collision_flag_reg, mode_fault_flag_reg, ovr_reg;
  select_mode_e  mode_reg;
  logic          tx_buffer_empty_reg, en_reg, master_reg, cpha_reg, cpol_reg;
  logic [7:0]    div_reg, tx_buf_reg, rx_buf_reg, rdata_reg;
  logic          rx_full_reg, irq_reg;
  // Shifter state
  master_state_e state_reg, state_next;
  logic [7:0]    tx_sh_reg, rx_sh_reg;
  logic [2:0]    bit_cnt_reg, hold_cnt_reg;
  logic [4:0]    half_cnt_reg;
  logic          srmt_reg, out_bit_reg, sck_reg;
  logic          sck_oe_reg, mosi_oe_reg, miso_oe_reg, nss_oe_reg, nss_out_reg;

  // Register decode
  wire wr_data = sfr_wr_i && (sfr_addr_i == ADDR_DATA);
  wire wr_ctl  = sfr_wr_i && (sfr_addr_i == ADDR_CTL);
  wire wr_cfg  = sfr_wr_i && (sfr_addr_i == ADDR_CFG);
  wire wr_div  = sfr_wr_i && (sfr_addr_i == ADDR_DIV);
  wire rd_data = sfr_rd_i && (sfr_addr_i == ADDR_DATA);

  // Operating mode
  wire is_master    = en_reg & master_reg;
  wire four_wire_in = (mode_reg == SEL_4WIRE_IN);
  wire nss_low      = ~pin_now[PIN_NSS];
  // Outside mode 01 the pin is not an input, so a slave counts as always selected
  wire slave_sel    = en_reg & ~master_reg & (~four_wire_in | nss_low);
  wire nss_fall     = four_wire_in & filt_reg[PIN_NSS] & nss_low;
  wire mode_fault   = master_reg & four_wire_in & nss_low;

  // Data register write acceptance
  wire tx_accept = wr_data & tx_buffer_empty_reg;
  wire collide   = wr_data & ~tx_buffer_empty_reg;

  // Slave edges from the filtered serial clock
  wire s_edge  = slave_sel & (pin_now[PIN_SCK] ^ filt_reg[PIN_SCK]);
  wire s_lead  = s_edge & (pin_now[PIN_SCK] != cpol_reg);
  wire s_trail = s_edge & (pin_now[PIN_SCK] == cpol_reg);

  // Master edges from the rate generator
  spi_rate_if rate_bus();
  assign rate_bus.run     = is_master & (state_reg == M_RUN);
  assign rate_bus.divider = div_reg;

  wire m_tick  = rate_bus.tick & (state_reg == M_RUN);
  wire m_lead  = m_tick & (sck_reg == cpol_reg);
  wire m_trail = m_tick & (sck_reg != cpol_reg);

  wire lead_ev   = master_reg ? m_lead  : s_lead;
  wire trail_ev  = master_reg ? m_trail : s_trail;
  wire sample_ev = cpha_reg ? trail_ev : lead_ev;
  // The trailing edge after the eighth bit of phase 0 must not shift the next byte
  wire shift_ev  = cpha_reg ? lead_ev : (trail_ev & (bit_cnt_reg != 3'h0));
  // Master sampling sees the input three clocks late, so slow dividers are safer
  wire sample_bit = master_reg ? pin_now[PIN_MISO] : pin_now[PIN_MOSI];

  wire slave_done  = ~master_reg & sample_ev & (bit_cnt_reg == LAST_BIT);
  wire master_done = m_tick & (half_cnt_reg == LAST_HALF);
  wire xfer_done   = slave_done | master_done;

  wire load_m = is_master & (state_reg == M_IDLE) & ~tx_buffer_empty_reg;
  wire load_s = en_reg & ~master_reg & srmt_reg & ~tx_buffer_empty_reg;
  wire load_w = load_m | load_s;

  // Receive path
  wire [7:0] rx_byte_w = sample_ev ? shl_in(rx_sh_reg, sample_bit) : rx_sh_reg;
  wire       ovr_set   = slave_done & rx_full_reg;
  wire       rx_store  = xfer_done & ~ovr_set;

  // Flags: hardware set wins over a software write in the same cycle
  wire done_next = xfer_done  | (wr_ctl ? sfr_wdata_i[CTL_DONE] : done_reg);
  wire write_collision_flag_next = collide    | (wr_ctl ? sfr_wdata_i[CTL_WRITE_COLLISION_FLAG] : write_collision_flag_reg);
  wire mode_fault_flag_next = mode_fault | (wr_ctl ? sfr_wdata_i[CTL_MODE_FAULT_FLAG] : mode_fault_flag_reg);
  wire ovr_next  = ovr_set    | (wr_ctl ? sfr_wdata_i[CTL_OVR]  : ovr_reg);
  wire en_next     = ~mode_fault & (wr_ctl ? sfr_wdata_i[CTL_EN] : en_reg);
  wire master_next = ~mode_fault & (wr_cfg ? sfr_wdata_i[CFG_MASTER] : master_reg);
  wire tx_buffer_empty_next  = load_w | (~tx_accept & tx_buffer_empty_reg);
  wire rx_full_next = rx_store | (rx_full_reg & ~rd_data);

  // Shifter next values
  wire [4:0] half_next = (load_m | ~is_master) ? 5'h00 :
                         m_tick ? half_cnt_reg + 5'h01 : half_cnt_reg;
  wire [2:0] bit_next  = (~en_reg | nss_fall | load_m) ? 3'h0 :
                         sample_ev ? bit_cnt_reg + 3'h1 : bit_cnt_reg;
  wire       srmt_next = ~en_reg | slave_done | (srmt_reg & ~load_s);
  wire [7:0] tx_sh_next = load_w ? tx_buf_reg :
                          shift_ev ? shl_in(tx_sh_reg, 1'b0) : tx_sh_reg;
  wire       out_next  = load_w ? tx_buf_reg[7] :
                         shift_ev ? (cpha_reg ? tx_sh_reg[7] : tx_sh_reg[6]) :
                         (hold_cnt_reg == 3'h1) ? tx_sh_reg[7] : out_bit_reg;
  wire [2:0] hold_next = (slave_done & cpha_reg) ? LAST_HOLD :
                         (hold_cnt_reg != 3'h0) ? hold_cnt_reg - 3'h1 : 3'h0;
  wire       sck_next  = (~is_master | (state_reg != M_RUN)) ? cpol_reg :
                         m_tick ? ~sck_reg : sck_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      M_IDLE:  state_next = load_m ? M_RUN : M_IDLE;
      M_RUN:   state_next = master_done ? M_IDLE : M_RUN;
      default: state_next = M_IDLE;
    endcase
    if (!is_master) begin
      state_next = M_IDLE;
    end
  end

  // Read multiplexer
  wire       busy_w  = (state_reg == M_RUN) | (~master_reg & (bit_cnt_reg != 3'h0));
  wire [7:0] ctl_rd  = {done_reg, write_collision_flag_reg, mode_fault_flag_reg, ovr_reg, mode_reg, tx_buffer_empty_reg, en_reg};
  wire [7:0] cfg_rd  = {busy_w, master_reg, cpha_reg, cpol_reg, nss_low, s2_reg[PIN_NSS],
                        master_reg | srmt_reg, master_reg | ~rx_full_reg};
  wire [7:0] rd_mux  = (sfr_addr_i == ADDR_DATA) ? rx_buf_reg :
                       (sfr_addr_i == ADDR_CTL)  ? ctl_rd :
                       (sfr_addr_i == ADDR_CFG)  ? cfg_rd :
                       (sfr_addr_i == ADDR_DIV)  ? div_reg : 8'h00;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {done_reg, write_collision_flag_reg, mode_fault_flag_reg, ovr_reg} <= CTL_RESET[CTL_DONE:CTL_OVR];
      mode_reg   <= select_mode_e'(CTL_RESET[CTL_MODE_HI:CTL_MODE_LO]);
      tx_buffer_empty_reg  <= CTL_RESET[CTL_TX_BUFFER_EMPTY];
      en_reg     <= CTL_RESET[CTL_EN];
      master_reg <= 1'b0;
      cpha_reg   <= 1'b0;
      cpol_reg   <= 1'b0;
      div_reg    <= DIV_RESET;
    end else if (ce_i) begin
      {done_reg, write_collision_flag_reg, mode_fault_flag_reg, ovr_reg} <= {done_next, write_collision_flag_next, mode_fault_flag_next, ovr_next};
      mode_reg   <= wr_ctl ? select_mode_e'(sfr_wdata_i[CTL_MODE_HI:CTL_MODE_LO]) : mode_reg;
      tx_buffer_empty_reg  <= tx_buffer_empty_next;
      en_reg     <= en_next;
      master_reg <= master_next;
      cpha_reg   <= wr_cfg ? sfr_wdata_i[CFG_CPHA] : cpha_reg;
      cpol_reg   <= wr_cfg ? sfr_wdata_i[CFG_CPOL] : cpol_reg;
      div_reg    <= wr_div ? sfr_wdata_i : div_reg;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_buf_reg  <= DATA_RESET;
      rx_buf_reg  <= DATA_RESET;
      rx_full_reg <= 1'b0;
      rdata_reg   <= 8'h00;
      irq_reg     <= 1'b0;
    end else if (ce_i) begin
      tx_buf_reg  <= tx_accept ? sfr_wdata_i : tx_buf_reg;
      rx_buf_reg  <= rx_store ? rx_byte_w : rx_buf_reg;
      rx_full_reg <= rx_full_next;
      rdata_reg   <= rd_mux;
      irq_reg     <= done_next | write_collision_flag_next | mode_fault_flag_next | ovr_next;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg    <= M_IDLE;
      half_cnt_reg <= 5'h00;
      bit_cnt_reg  <= 3'h0;
      hold_cnt_reg <= 3'h0;
      srmt_reg     <= 1'b1;
      tx_sh_reg    <= 8'h00;
      rx_sh_reg    <= 8'h00;
      out_bit_reg  <= 1'b0;
      sck_reg      <= 1'b0;
    end else if (ce_i) begin
      state_reg    <= state_next;
      half_cnt_reg <= half_next;
      bit_cnt_reg  <= bit_next;
      hold_cnt_reg <= hold_next;
      srmt_reg     <= srmt_next;
      tx_sh_reg    <= tx_sh_next;
      rx_sh_reg    <= rx_byte_w;
      out_bit_reg  <= out_next;
      sck_reg      <= sck_next;
    end
  end

  // Pin drivers; the slave relies on the master's select and data margins
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_oe_reg  <= 1'b0;
      mosi_oe_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
      nss_oe_reg  <= 1'b0;
      nss_out_reg <= 1'b1;
    end else if (ce_i) begin
      sck_oe_reg  <= is_master;
      mosi_oe_reg <= is_master;
      miso_oe_reg <= slave_sel;
      nss_oe_reg  <= mode_reg[1];
      nss_out_reg <= mode_reg[1] ? mode_reg[0] : 1'b1;
    end
  end

  spi_rate_gen u_rate (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .rate      (rate_bus.gen)
  );

  assign sfr_rdata_o         = rdata_reg;
  assign irq_o               = irq_reg;
  assign sck_o               = sck_reg;
  assign sck_oe_o            = sck_oe_reg;
  assign mosi_o              = out_bit_reg;
  assign mosi_oe_o           = mosi_oe_reg;
  assign miso_o              = out_bit_reg;
  assign miso_oe_o           = miso_oe_reg;
  assign slave_select_n_o    = nss_out_reg;
  assign slave_select_n_oe_o = nss_oe_reg;

  // Checks
  logic [7:0] gap_reg;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_reg <= 8'h00;
    end else if (ce_i) begin
      gap_reg <= m_tick ? 8'h00 : gap_reg + 8'h01;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_done_sets: assert property (ce_i && xfer_done |=> done_reg && irq_o)
    else $error("done flag or irq missing after transfer");
  a_collision_sets: assert property (ce_i && collide |=> write_collision_flag_reg && tx_buf_reg == $past(tx_buf_reg))
    else $error("collision not flagged or buffer overwritten");
  a_fault_disables: assert property (ce_i && mode_fault |=> mode_fault_flag_reg && !en_reg && !master_reg)
    else $error("mode fault did not disable the port");
  a_overrun_keeps: assert property (ce_i && ovr_set |=> ovr_reg && rx_buf_reg == $past(rx_buf_reg))
    else $error("overrun not flagged or buffer replaced");
  a_flags_sticky: assert property (ce_i && !wr_ctl |=>
      (({done_reg, write_collision_flag_reg, mode_fault_flag_reg, ovr_reg} & $past({done_reg, write_collision_flag_reg, mode_fault_flag_reg, ovr_reg}))
       == $past({done_reg, write_collision_flag_reg, mode_fault_flag_reg, ovr_reg})))
    else $error("hardware cleared a sticky flag");
  a_select_input: assert property (ce_i && !mode_reg[1] |=> !slave_select_n_oe_o)
    else $error("select pin driven outside drive modes");
  a_select_drive: assert property (ce_i && mode_reg[1] |=>
      slave_select_n_oe_o && slave_select_n_o == $past(mode_reg[0]))
    else $error("select pin does not follow mode low bit");
  a_tx_buffer_empty_write: assert property (ce_i && tx_accept |=> !tx_buffer_empty_reg)
    else $error("buffer empty bit did not drop on write");
  a_sck_half: assert property (ce_i && m_tick && half_cnt_reg != 5'h00 |-> gap_reg == div_reg)
    else $error("serial clock half period wrong");
  a_sck_idle: assert property (ce_i && state_reg == M_IDLE |=> sck_o == $past(cpol_reg))
    else $error("serial clock not at idle level");
  a_miso_release: assert property (
      (four_wire_in && !master_reg && $rose(slave_select_n_i) && ce_i)
      ##1 (slave_select_n_i && ce_i && four_wire_in)[*3] |=> !miso_oe_o)
    else $error("slave output not released in time");
  a_last_hold: assert property (ce_i && hold_cnt_reg == 3'h1 && !load_w && !shift_ev |=>
      out_bit_reg == $past(tx_sh_reg[7]))
    else $error("late output change missing");

  c_master_xfer: cover property (ce_i && master_done);
  c_slave_xfer:  cover property (ce_i && slave_done && !rx_full_reg);
  c_mode_fault:  cover property (ce_i && mode_fault);
  c_collision:   cover property (ce_i && collide);
endmodule // spi_port

// ==== tb/spi_slave_model.sv ====
module spi_slave_model (
  // Link pins
  input  logic       sck_i,
  input  logic       mosi_i,
  input  logic       sel_n_i,
  input  logic       cpol_i,
  output logic       miso_o,
  output logic       miso_en_o,
  // Byte to answer with, byte heard
  input  logic [7:0] tx_byte_i,
  output logic [7:0] rx_byte_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] shift_q = 8'h00;
  logic [3:0] cnt_q = 4'h0;
  initial rx_byte_o = 8'h00;
  assign miso_o = shift_q[7];
  // Released when not selected; the bench then scrambles the line
  assign miso_en_o = !sel_n_i;
  always @(negedge sel_n_i) begin
    shift_q = tx_byte_i;
    cnt_q = 4'h0;
  end
  // Sample on the leading edge, shift on the trailing one
  always @(sck_i) begin
    if (!sel_n_i && (sck_i ^ cpol_i)) begin
      rx_byte_o = {rx_byte_o[6:0], mosi_i};
      cnt_q = cnt_q + 4'h1;
    end else if (!sel_n_i && cnt_q == 4'h8) begin
      shift_q = tx_byte_i;
      cnt_q = 4'h0;
    end else if (!sel_n_i) begin
      shift_q = {shift_q[6:0], 1'b0};
    end
  end
endmodule // spi_slave_model

// ==== tb/spi_control_clock_data_tb_top.sv ====
module spi_control_clock_data_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import spi_pkg::*;
  logic       clk_sys_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic       sfr_wr_i = 1'b0;
  logic       sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] sfr_rdata_o;
  logic       irq_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
  logic       slave_select_n_o, slave_select_n_oe_o;
  logic       m_sck = 1'b0, m_mosi = 1'b0, m_sel = 1'b1, miso_q = 1'b0;
  logic       p_cpol = 1'b0, p_miso, p_en;
  logic [7:0] p_tx = 8'h3c, p_rx, got;
  int         fails = 0, comparisons = 0;
  wire sck_w  = sck_oe_o ? sck_o : m_sck;
  wire mosi_w = mosi_oe_o ? mosi_o : m_mosi;
  wire sel_w  = slave_select_n_oe_o ? slave_select_n_o : m_sel;
  // An undriven data line changes every cycle so a stale bit never passes
  wire miso_w = miso_oe_o ? miso_o : (p_en ? p_miso : ~miso_q);
  always #50 clk_sys_i = ~clk_sys_i;
  // An unknown line counts as 0 here, so the inverse never sticks at X
  always @(posedge clk_sys_i) miso_q <= (miso_w === 1'b1);

  spi_port i_spi_port (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .irq_o(irq_o),
    .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
    .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o),
    .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
    .slave_select_n_i(sel_w), .slave_select_n_o(slave_select_n_o),
    .slave_select_n_oe_o(slave_select_n_oe_o));
  spi_slave_model i_spi_slave_model (.sck_i(sck_w), .mosi_i(mosi_w), .sel_n_i(sel_w),
    .cpol_i(p_cpol), .miso_o(p_miso), .miso_en_o(p_en), .tx_byte_i(p_tx),
    .rx_byte_o(p_rx));

  task automatic final_report();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // Strobes drop after one edge and an idle edge follows, so calls may chain
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    tick(1);
    sfr_wr_i = 1'b0;
    tick(1);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    tick(1);
    d = sfr_rdata_o;
    sfr_rd_i = 1'b0;
    tick(1);
    check(d & m, e);
  endtask
  // Waits for the end of a master transfer, checking the clock spacing
  task automatic wait_master(input logic [7:0] div, input bit count);
    int n, last, tog;
    logic prev;
    tick(1);
    prev = sck_o;
    last = -1;
    tog = 0;
    for (n = 0; n < 600 && irq_o !== 1'b1; n++) begin
      tick(1);
      if (sck_o !== prev) begin
        if (last >= 0) check(8'(n - last), div + 8'h01);
        last = n;
        tog++;
        prev = sck_o;
      end
    end
    if (count) check(8'(tog), 8'h10);
    if (irq_o !== 1'b1) begin
      fails++;
      final_report();
    end
  endtask
  // Bench acts as an outside master with wide setup and hold margins
  // Phase 1 moves the data line on the rising edge and samples on the falling one
  task automatic slave_byte(input logic [7:0] mo, output logic [7:0] mi, input bit ph);
    m_sel = 1'b0;
    tick(4);
    check({7'h0, miso_oe_o}, 8'h01);
    for (int i = 7; i >= 0; i--) begin
      if (!ph) m_mosi = mo[i];
      tick(6);
      m_sck = 1'b1;
      if (ph) m_mosi = mo[i];
      else mi[i] = miso_w;
      tick(6);
      m_sck = 1'b0;
      if (ph) mi[i] = miso_w;
    end
    // Phase 1 callers load a byte whose last bit is 1; the empty shifter then shows 0
    if (ph) begin
      tick(5);
      check({7'h0, miso_o}, 8'h01);
      tick(3);
      check({7'h0, miso_o}, 8'h00);
    end
    tick(6);
    m_sel = 1'b1;
    tick(4);
    check({7'h0, miso_oe_o}, 8'h00);
  endtask

  initial begin
    tick(2);
    rst_n_i = 1'b1;
    rc(ADDR_CTL, 8'hff, 8'h06);
    rc(ADDR_DIV, 8'hff, 8'h00);
    rc(ADDR_DATA, 8'hff, 8'h00);
    rc(ADDR_CFG, 8'hff, 8'h07);
    rc(8'h55, 8'hff, 8'h00);
    $display("test reset values done");
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CTL, {4'h0, 2'(m), 2'b00});
      tick(2);
      check({6'h0, slave_select_n_oe_o, slave_select_n_o & m[1]},
            {6'h0, m[1], m[1] & m[0]});
    end
    $display("test select modes done");
    wr(ADDR_CFG, 8'h40);
    wr(ADDR_CTL, 8'h05);
    m_sel = 1'b0;
    tick(8);
    rc(ADDR_CTL, 8'hff, 8'h26);
    rc(ADDR_CFG, 8'h40, 8'h00);
    check({7'h0, irq_o}, 8'h01);
    tick(40);
    rc(ADDR_CTL, 8'hff, 8'h26);
    m_sel = 1'b1;
    wr(ADDR_CTL, 8'h05);
    rc(ADDR_CTL, 8'hff, 8'h07);
    $display("test mode fault done");
    wr(ADDR_DATA, 8'h96);
    slave_byte(8'h5a, got, 1'b0);
    check(got, 8'h96);
    rc(ADDR_CTL, 8'hff, 8'h87);
    slave_byte(8'hc3, got, 1'b0);
    rc(ADDR_CTL, 8'hff, 8'h97);
    rc(ADDR_DATA, 8'hff, 8'h5a);
    wr(ADDR_CTL, 8'h04);
    wr(ADDR_CFG, 8'h20);
    wr(ADDR_CTL, 8'h05);
    wr(ADDR_DATA, 8'h69);
    slave_byte(8'h3b, got, 1'b1);
    check(got, 8'h69);
    rc(ADDR_DATA, 8'hff, 8'h3b);
    wr(ADDR_CTL, 8'h04);
    $display("test slave transfer done");
    wr(ADDR_DIV, 8'h04);
    wr(ADDR_CFG, 8'h40);
    wr(ADDR_CTL, 8'h09);
    wr(ADDR_DATA, 8'ha5);
    wait_master(8'h04, 1'b1);
    check(p_rx, 8'ha5);
    rc(ADDR_CTL, 8'hff, 8'h8b);
    rc(ADDR_DATA, 8'hff, 8'h3c);
    wr(ADDR_CTL, 8'h09);
    wr(ADDR_DATA, 8'h81);
    tick(2);
    wr(ADDR_DATA, 8'h42);
    wr(ADDR_DATA, 8'h17);
    rc(ADDR_CTL, 8'hff, 8'h49);
    check({7'h0, irq_o}, 8'h01);
    wr(ADDR_CTL, 8'h09);
    wait_master(8'h04, 1'b0);
    check(p_rx, 8'h81);
    wr(ADDR_CTL, 8'h09);
    wait_master(8'h04, 1'b0);
    check(p_rx, 8'h42);
    rc(ADDR_CTL, 8'hff, 8'h8b);
    $display("test master transfer done");
    p_cpol = 1'b1;
    wr(ADDR_CFG, 8'h50);
    tick(3);
    check({7'h0, sck_o}, 8'h01);
    wr(ADDR_CTL, 8'h08);
    wr(ADDR_DATA, 8'h11);
    tick(30);
    check({6'h0, sck_oe_o, irq_o}, 8'h00);
    $display("test polarity and disable done");
    final_report();
  end
endmodule // spi_control_clock_data_tb_top
